/* shared/coord_defines.svh */
// Purpose: constants of the coordinate / accumulator command block
// Assumes: included by bare name
// Notes: status codes other than ok are chosen for this block
`ifndef COORD_DEFINES_SVH
`define COORD_DEFINES_SVH
// instruction numbers
`define OP_READ_COORD 8'h1f
`define OP_CAPTURE 8'h20
`define OP_XREG_CALCULATE_CMD 8'h21
`define OP_ACC_PARAM 8'h22
`define OP_ACC_COORD 8'h27
// special forms
`define BANK_NV 8'hff
`define COORD_FIRST_NV 8'h01
// frame layout: byte 8 is the checksum
`define FRAME_LAST 4'h8
`define FB_ADDR 0
`define FB_INSTR 1
`define FB_TYPE 2
`define FB_MOTOR 3
// reply status
`define ST_OK 8'h64
`define ST_BAD_SUM 8'h01
`define ST_BAD_CMD 8'h02
`define ST_BAD_TYPE 8'h03
`define ST_BAD_VAL 8'h04
`endif

/* shared/coord_pkg.sv */
// Purpose: types of the coordinate / accumulator command block
// Assumes: nothing
// Notes: operation codes follow the calculate type field
package coord_pkg;
  typedef logic signed [31:0] word_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_NV_RD = 3'b010,
    ST_NV_WR = 3'b011
  } state_t;
  typedef enum logic [3:0] {
    OP_ADD = 4'h0, OP_SUB = 4'h1, OP_MUL = 4'h2, OP_DIV = 4'h3,
    OP_MOD = 4'h4, OP_AND = 4'h5, OP_OR = 4'h6, OP_XOR = 4'h7,
    OP_NOT = 4'h8, OP_LOAD = 4'h9, OP_SWAP = 4'ha
  } calc_op_t;
endpackage

/* verilog/coord_accum_cmd.sv */
// Purpose: executes coordinate, accumulator and x register commands
// Assumes: one clock; nv storage answers each request with an ack pulse
// Notes: frames from the serial link are direct mode, program port
//   commands are standalone mode; one command is in flight at a time
// Operation
// - read-coordinate 0,255,0 reloads all entries but zero from nv storage
// - read-coordinate n,255,0 reloads entry n only; n must be 1 to 20
// - capture stores the axis actual position into the chosen entry
// - entry zero lives in ram only, never saved nor reloaded
// - persistence option selects ram only or ram plus nv; reset: ram only
// - capture in direct mode replies 100 with the captured value
// - accum-to-coordinate writes the accumulator to the entry, replies 100
// - x calculate uses accumulator and x register, result into accumulator
// - types 0..7: add, sub, mul, div, mod, and, or, xor
// - type 8 inverts the x register
// - type 9 copies accumulator to x; type 10 swaps them
// - accum-to-axis-param writes accumulator to parameter type of motor
// - frame: address, instruction, type, motor, value msb first, checksum
// - accum-to-axis-param is instruction 34
`timescale 1ns/1ps
`include "coord_defines.svh"
`default_nettype none
module coord_accum_cmd #(
  parameter int AXES = 6,
  parameter int COORDS = 20,
  parameter logic [7:0] MODULE_ADDR = 8'h01
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // serial frame bytes
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_valid_in,
  // stored program command
  input wire logic prog_valid_in,
  input wire logic [7:0] prog_instr_in,
  input wire logic [7:0] prog_type_in,
  input wire logic [7:0] prog_motor_in,
  input wire coord_pkg::word_t prog_value_in,
  // motion engine actual positions, axis k at bits 32k+31..32k
  input wire logic [AXES*32-1:0] actual_pos_in,
  // persistence option and start-up load
  input wire logic persist_wr_in,
  input wire logic persist_val_in,
  input wire logic boot_load_in,
  output logic persist_out,
  // nonvolatile storage
  output logic nv_rd_out,
  output logic nv_wr_out,
  output logic [7:0] nv_axis_out,
  output logic [7:0] nv_coord_out,
  output coord_pkg::word_t nv_wdata_out,
  input wire logic nv_ack_in,
  input wire coord_pkg::word_t nv_rdata_in,
  // axis parameter write
  output logic param_wr_out,
  output logic [7:0] param_idx_out,
  output logic [7:0] param_axis_out,
  output coord_pkg::word_t param_data_out,
  // reply
  output logic ready_out,
  output logic reply_valid_out,
  output logic reply_direct_out,
  output logic [7:0] reply_instr_out,
  output logic [7:0] reply_status_out,
  output coord_pkg::word_t reply_value_out
);
  import coord_pkg::*;

  localparam int AW = (AXES > 1) ? $clog2(AXES) : 1;
  localparam int CW = $clog2(COORDS + 1);
  localparam logic [7:0] AXIS_LAST = 8'(AXES - 1);
  localparam logic [7:0] COORD_LAST = 8'(COORDS);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // coordinate index and axis both in range
  function automatic logic sel_ok(input logic [7:0] c, input logic [7:0] a);
    sel_ok = (c <= COORD_LAST) && (a <= AXIS_LAST);
  endfunction

  // accumulator / x register arithmetic; div and mod by zero keep acc
  function automatic word_t calc(input logic [3:0] op, input word_t a,
                                 input word_t x);
    calc = a;
    case (op)
      OP_ADD: calc = a + x;
      OP_SUB: calc = a - x;
      OP_MUL: calc = 32'(a * x);
      OP_DIV: calc = (x != 0) ? a / x : a;
      OP_MOD: calc = (x != 0) ? a % x : a;
      OP_AND: calc = a & x;
      OP_OR: calc = a | x;
      OP_XOR: calc = a ^ x;
      OP_SWAP: calc = x;
      default: calc = a;
    endcase
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sum_q;
  logic [7:0] fb_q [0:7];
  logic [7:0] instr_q, type_q, motor_q;
  word_t value_q, acc_q, x_q;
  logic direct_q, sum_bad_q, walk_all_q, boot_q;
  word_t coord_mem [AXES][COORDS+1];

  logic frame_done, take_frame, take_prog, mem_we, nv_form;
  logic [AW-1:0] wa;
  logic [CW-1:0] wc;
  word_t wd, rd_word, pos_word;

  // ------------------------------------------------------------
  // frame assembly
  // ------------------------------------------------------------
  // bytes are stored in arrival order, value msb first
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q <= 4'h0;
      sum_q <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        fb_q[i] <= 8'h00;
      end
    end else if (ce_in && rx_valid_in) begin
      if (cnt_q == `FRAME_LAST) begin
        cnt_q <= 4'h0;
        sum_q <= 8'h00;
      end else begin
        fb_q[cnt_q[2:0]] <= rx_byte_in;
        sum_q <= sum_q + rx_byte_in;
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  // a frame that completes while busy or for another address is dropped
  assign frame_done = ce_in && rx_valid_in && (cnt_q == `FRAME_LAST);
  assign take_frame = frame_done && (st_q == ST_IDLE) &&
                      (fb_q[`FB_ADDR] == MODULE_ADDR);
  assign take_prog = ce_in && prog_valid_in && (st_q == ST_IDLE) &&
                     !take_frame && !boot_load_in;

  // ------------------------------------------------------------
  // decode and coordinate array access
  // ------------------------------------------------------------
  assign nv_form = (motor_q == `BANK_NV) && (value_q == 0);
  assign rd_word = coord_mem[motor_q[AW-1:0]][type_q[CW-1:0]];
  assign pos_word = actual_pos_in[motor_q[AW-1:0]*32 +: 32];

  // reloads never touch entry zero: the walker starts at one
  always_comb begin
    mem_we = 1'b0;
    wa = motor_q[AW-1:0];
    wc = type_q[CW-1:0];
    wd = acc_q;
    if (st_q == ST_NV_RD) begin
      mem_we = nv_ack_in;
      wa = nv_axis_out[AW-1:0];
      wc = nv_coord_out[CW-1:0];
      wd = nv_rdata_in;
    end else if (st_q == ST_EXEC && !sum_bad_q &&
                 sel_ok(type_q, motor_q)) begin
      if (instr_q == `OP_CAPTURE) begin
        mem_we = 1'b1;
        wd = pos_word;
      end else if (instr_q == `OP_ACC_COORD) begin
        mem_we = 1'b1;
      end
    end
  end

  // array has no reset; entries are data, not control
  always_ff @(posedge clk_in) begin
    if (ce_in && mem_we) begin
      coord_mem[wa][wc] <= wd;
    end
  end

  // ------------------------------------------------------------
  // persistence option
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      persist_out <= 1'b0;
    end else if (ce_in && persist_wr_in) begin
      persist_out <= persist_val_in;
    end
  end

  // ------------------------------------------------------------
  // accumulator and x register
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_q <= 32'h0000_0000;
      x_q <= 32'h0000_0000;
    end else if (ce_in && st_q == ST_EXEC && !sum_bad_q) begin
      if (instr_q == `OP_XREG_CALCULATE_CMD && type_q <= {4'h0, OP_SWAP}) begin
        acc_q <= calc(type_q[3:0], acc_q, x_q);
        if (type_q[3:0] == OP_NOT) begin
          x_q <= ~x_q;
        end else if (type_q[3:0] == OP_LOAD || type_q[3:0] == OP_SWAP) begin
          x_q <= acc_q;
        end
      end else if (instr_q == `OP_READ_COORD && !direct_q && !nv_form &&
                   sel_ok(type_q, motor_q)) begin
        acc_q <= rd_word; // standalone read loads the accumulator
      end
    end
  end

  // ------------------------------------------------------------
  // command sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_q <= ST_IDLE;
      instr_q <= 8'h00;
      type_q <= 8'h00;
      motor_q <= 8'h00;
      value_q <= 32'h0000_0000;
      direct_q <= 1'b0;
      sum_bad_q <= 1'b0;
      walk_all_q <= 1'b0;
      boot_q <= 1'b0;
      ready_out <= 1'b0;
      nv_rd_out <= 1'b0;
      nv_wr_out <= 1'b0;
      nv_axis_out <= 8'h00;
      nv_coord_out <= 8'h00;
      nv_wdata_out <= 32'h0000_0000;
      param_wr_out <= 1'b0;
      param_idx_out <= 8'h00;
      param_axis_out <= 8'h00;
      param_data_out <= 32'h0000_0000;
      reply_valid_out <= 1'b0;
      reply_direct_out <= 1'b0;
      reply_instr_out <= 8'h00;
      reply_status_out <= 8'h00;
      reply_value_out <= 32'h0000_0000;
    end else if (ce_in) begin
      reply_valid_out <= 1'b0;
      param_wr_out <= 1'b0;
      ready_out <= (st_q == ST_IDLE) && !take_frame && !take_prog;
      case (st_q)
        ST_IDLE: begin
          if (take_frame) begin
            instr_q <= fb_q[`FB_INSTR];
            type_q <= fb_q[`FB_TYPE];
            motor_q <= fb_q[`FB_MOTOR];
            value_q <= {fb_q[4], fb_q[5], fb_q[6], fb_q[7]};
            sum_bad_q <= (sum_q != rx_byte_in);
            direct_q <= 1'b1;
            st_q <= ST_EXEC;
          end else if (boot_load_in && persist_out) begin
            // start-up reload only when persistence is on
            boot_q <= 1'b1;
            walk_all_q <= 1'b1;
            nv_axis_out <= 8'h00;
            nv_coord_out <= `COORD_FIRST_NV;
            nv_rd_out <= 1'b1;
            st_q <= ST_NV_RD;
          end else if (take_prog) begin
            instr_q <= prog_instr_in;
            type_q <= prog_type_in;
            motor_q <= prog_motor_in;
            value_q <= prog_value_in;
            sum_bad_q <= 1'b0;
            direct_q <= 1'b0;
            st_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          boot_q <= 1'b0;
          reply_direct_out <= direct_q;
          reply_instr_out <= instr_q;
          reply_value_out <= 32'h0000_0000;
          reply_status_out <= `ST_OK;
          reply_valid_out <= 1'b1;
          st_q <= ST_IDLE;
          if (sum_bad_q) begin
            reply_status_out <= `ST_BAD_SUM;
          end else begin
            case (instr_q)
              `OP_READ_COORD: begin
                if (nv_form && type_q == 8'h00) begin
                  walk_all_q <= 1'b1;
                  nv_axis_out <= 8'h00;
                  nv_coord_out <= `COORD_FIRST_NV;
                  nv_rd_out <= 1'b1;
                  reply_valid_out <= 1'b0;
                  st_q <= ST_NV_RD;
                end else if (nv_form && type_q <= COORD_LAST) begin
                  // one entry, refreshed on every axis
                  walk_all_q <= 1'b0;
                  nv_axis_out <= 8'h00;
                  nv_coord_out <= type_q;
                  nv_rd_out <= 1'b1;
                  reply_valid_out <= 1'b0;
                  st_q <= ST_NV_RD;
                end else if (!nv_form && sel_ok(type_q, motor_q)) begin
                  reply_value_out <= direct_q ? rd_word : 32'h0000_0000;
                end else begin
                  reply_status_out <= `ST_BAD_VAL;
                end
              end
              `OP_CAPTURE, `OP_ACC_COORD: begin
                if (!sel_ok(type_q, motor_q)) begin
                  reply_status_out <= `ST_BAD_VAL;
                end else begin
                  if (instr_q == `OP_CAPTURE) begin
                    reply_value_out <= pos_word;
                  end
                  // entry zero is never written to nv storage
                  if (persist_out && type_q != 8'h00) begin
                    nv_axis_out <= motor_q;
                    nv_coord_out <= type_q;
                    nv_wdata_out <= (instr_q == `OP_CAPTURE) ? pos_word : acc_q;
                    nv_wr_out <= 1'b1;
                    reply_valid_out <= 1'b0;
                    st_q <= ST_NV_WR;
                  end
                end
              end
              `OP_XREG_CALCULATE_CMD: begin
                if (type_q > {4'h0, OP_SWAP}) begin
                  reply_status_out <= `ST_BAD_TYPE;
                end
              end
              `OP_ACC_PARAM: begin
                if (motor_q > AXIS_LAST) begin
                  reply_status_out <= `ST_BAD_VAL;
                end else begin
                  param_idx_out <= type_q;
                  param_axis_out <= motor_q;
                  param_data_out <= acc_q;
                  param_wr_out <= 1'b1;
                end
              end
              default: begin
                reply_status_out <= `ST_BAD_CMD;
              end
            endcase
          end
        end
        ST_NV_RD: begin
          // step to the next entry on each ack
          if (nv_ack_in) begin
            if (walk_all_q && nv_coord_out != COORD_LAST) begin
              nv_coord_out <= nv_coord_out + 8'h01;
            end else if (nv_axis_out != AXIS_LAST) begin
              nv_axis_out <= nv_axis_out + 8'h01;
              if (walk_all_q) begin
                nv_coord_out <= `COORD_FIRST_NV;
              end
            end else begin
              nv_rd_out <= 1'b0;
              reply_valid_out <= !boot_q; // boot load is not answered
              reply_status_out <= `ST_OK;
              reply_value_out <= 32'h0000_0000;
              reply_direct_out <= direct_q;
              reply_instr_out <= instr_q;
              boot_q <= 1'b0;
              st_q <= ST_IDLE;
            end
          end
        end
        ST_NV_WR: begin
          if (nv_ack_in) begin
            nv_wr_out <= 1'b0;
            reply_valid_out <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* sim/coord_accum_cmd_asserts.sv */
// Purpose: port checks for the coordinate command block
// Assumes: one clock, async active-low reset, clock enable held high
// Notes: bound to every instance of the block
`timescale 1ns/1ps
`include "coord_defines.svh"
`default_nettype none
module coord_accum_cmd_asserts (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // persistence option
  input wire logic persist_wr_in,
  input wire logic persist_val_in,
  input wire logic persist_out,
  // nv storage
  input wire logic nv_rd_out,
  input wire logic nv_wr_out,
  input wire logic [7:0] nv_coord_out,
  input wire coord_pkg::word_t nv_wdata_out,
  input wire logic nv_ack_in,
  // parameter write and reply
  input wire logic param_wr_out,
  input wire logic reply_valid_out,
  input wire logic [7:0] reply_instr_out,
  input wire logic [7:0] reply_status_out
);
  import coord_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_reply_one_cycle: assert property (reply_valid_out |=> !reply_valid_out)
    else $error("reply valid held longer than one cycle");
  a_param_with_reply: assert property (param_wr_out |-> reply_valid_out &&
    reply_instr_out == `OP_ACC_PARAM && reply_status_out == `ST_OK)
    else $error("parameter write without its ok reply");
  a_persist_write: assert property (persist_wr_in |=> persist_out == $past(persist_val_in))
    else $error("persistence option not taken");
  a_persist_hold: assert property (!persist_wr_in |=> $stable(persist_out))
    else $error("persistence option changed unasked");
  a_nv_skip_zero: assert property ((nv_rd_out || nv_wr_out) |-> nv_coord_out != 8'h00)
    else $error("entry zero reached nv storage");
  a_nv_in_range: assert property (nv_rd_out |-> nv_coord_out <= 8'h14)
    else $error("reload beyond entry twenty");
  a_wr_needs_persist: assert property (nv_wr_out |-> persist_out)
    else $error("nv write in ram only mode");
  // a write request must sit still until storage takes it
  a_wr_hold: assert property (nv_wr_out && !nv_ack_in |=>
    nv_wr_out && $stable(nv_wdata_out) && $stable(nv_coord_out))
    else $error("nv write dropped or changed before ack");
  a_wr_then_reply: assert property (nv_wr_out && nv_ack_in |-> ##[1:2] reply_valid_out)
    else $error("no reply after nv write ack");
  a_calc_status: assert property (reply_valid_out && reply_instr_out == `OP_XREG_CALCULATE_CMD |->
    reply_status_out inside {`ST_OK, `ST_BAD_TYPE})
    else $error("calculate reply status wrong");
  a_rd_wr_apart: assert property (!(nv_rd_out && nv_wr_out))
    else $error("nv read and write together");
  c_param: cover property (param_wr_out);
  c_nv_wr: cover property (nv_wr_out && nv_ack_in);
  c_nv_rd: cover property (nv_rd_out && nv_ack_in);
endmodule
bind coord_accum_cmd coord_accum_cmd_asserts chk (.*);
`default_nettype wire

/* sim/coord_host_model.sv */
// Purpose: host sending command frames, plus nv storage of the module
// Assumes: called and clocked at falling edges
// Notes: storage answers prompt and slow in turn
`timescale 1ns/1ps
`default_nettype none
module coord_host_model #(
  parameter logic [7:0] ADDR = 8'h01
) (
  // clock
  input wire logic clk_in,
  // frame bytes
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  // nv storage
  input wire logic nv_rd_in,
  input wire logic nv_wr_in,
  input wire logic [7:0] nv_axis_in,
  input wire logic [7:0] nv_coord_in,
  output logic nv_ack_out,
  output coord_pkg::word_t nv_rdata_out
);
  import coord_pkg::*;
  int rd_acks = 0;
  int wr_acks = 0;
  int wait_q = 0;
  int lat = 0;
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    nv_ack_out = 1'b0;
    nv_rdata_out = 32'sh0;
  end
  // whole frame, one byte a cycle; idle byte lines show a changed value
  task automatic send_frame(input logic [7:0] i, t, m, input logic bad);
    logic [7:0] b [9];
    b = '{ADDR, i, t, m, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int k = 0; k < 8; k++) b[8] = b[8] + b[k];
    if (bad) b[8] = ~b[8];
    for (int k = 0; k < 9; k++) begin
      rx_byte_out = b[k];
      rx_valid_out = 1'b1;
      @(negedge clk_in);
    end
    rx_valid_out = 1'b0;
    rx_byte_out = ~rx_byte_out;
  endtask
  // storage data carries its own address so misplaced entries show up
  always @(negedge clk_in) begin
    if (nv_ack_out) begin
      nv_ack_out <= 1'b0;
      nv_rdata_out <= ~nv_rdata_out;
    end else if ((nv_rd_in || nv_wr_in) && wait_q >= lat) begin
      nv_ack_out <= 1'b1;
      nv_rdata_out <= {nv_axis_in, 16'h0a5c, nv_coord_in};
      wait_q <= 0;
      lat <= 2 - lat;
      rd_acks <= rd_acks + int'(nv_rd_in);
      wr_acks <= wr_acks + int'(nv_wr_in);
    end else if (nv_rd_in || nv_wr_in) begin
      wait_q <= wait_q + 1;
    end
  end
endmodule
`default_nettype wire

/* sim/coordinate_accumulator_commands_tb_top.sv */
// Purpose: self-checking bench for the coordinate command block
// Assumes: default address, six axes, clock enable high, boot load driven only in t_boot
// Notes: accumulator is read back through the parameter write port
`timescale 1ns/1ps
`include "coord_defines.svh"
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module coordinate_accumulator_commands_tb_top;
  import coord_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ce_in = 1'b1;
  logic boot_load_in = 1'b0;
  logic prog_valid_in = 1'b0, persist_wr_in = 1'b0, persist_val_in = 1'b0;
  logic [7:0] prog_instr_in = 8'h00, prog_type_in = 8'h00, prog_motor_in = 8'h00;
  word_t prog_value_in = 32'sh0;
  logic [191:0] actual_pos_in = {96'h0, 32'h12345678, 32'hffffffec, 32'h00000006};
  logic [7:0] rx_byte_in, nv_axis_out, nv_coord_out, param_idx_out, param_axis_out;
  logic [7:0] reply_instr_out, reply_status_out, st, pi, pa;
  logic rx_valid_in, persist_out, nv_rd_out, nv_wr_out, nv_ack_in, param_wr_out;
  logic ready_out, reply_valid_out, reply_direct_out, pw, dr;
  word_t nv_wdata_out, nv_rdata_in, param_data_out, reply_value_out, va, pd;
  int errors = 0;
  int checked = 0;
  always #12.5 clk_in = ~clk_in;
  coord_accum_cmd DUT (.*);
  coord_host_model host (.clk_in(clk_in), .rx_byte_out(rx_byte_in),
    .rx_valid_out(rx_valid_in), .nv_rd_in(nv_rd_out), .nv_wr_in(nv_wr_out),
    .nv_axis_in(nv_axis_out), .nv_coord_in(nv_coord_out), .nv_ack_out(nv_ack_in),
    .nv_rdata_out(nv_rdata_in));
  task automatic complete_run();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // one command, frame (d=1) or program port, value field zero
  // ----------------------------------------
  task automatic cmd(input logic d, input logic [7:0] i, t, m, input logic bad);
    int n;
    for (n = 0; n < 50 && ready_out !== 1'b1; n++) @(negedge clk_in);
    if (n == 50) begin
      errors++;
      complete_run();
    end
    if (d) begin
      host.send_frame(i, t, m, bad);
    end else begin
      {prog_instr_in, prog_type_in, prog_motor_in} = {i, t, m};
      prog_valid_in = 1'b1;
      @(negedge clk_in);
      prog_valid_in = 1'b0;
    end
    for (n = 0; n < 1000 && reply_valid_out !== 1'b1; n++) @(negedge clk_in);
    if (n == 1000) begin
      errors++;
      complete_run();
    end
    {st, va, dr} = {reply_status_out, reply_value_out, reply_direct_out};
    {pw, pi, pa, pd} = {param_wr_out, param_idx_out, param_axis_out, param_data_out};
    @(negedge clk_in);
  endtask
  task automatic t_capture();
    cmd(1, `OP_CAPTURE, 8'h03, 8'h02, 1'b0);
    `CHK("capture reply", {`ST_OK, 32'h12345678, 1'b1}, {st, va, dr})
    cmd(1, `OP_READ_COORD, 8'h03, 8'h02, 1'b0);
    `CHK("captured entry", 32'h12345678, va)
    cmd(1, `OP_CAPTURE, 8'h01, 8'h00, 1'b0);
    cmd(1, `OP_CAPTURE, 8'h01, 8'h01, 1'b0);
    cmd(1, `OP_CAPTURE, 8'h00, 8'h00, 1'b0);
  endtask
  task automatic t_acc_coord();
    cmd(0, `OP_READ_COORD, 8'h03, 8'h02, 1'b0);
    `CHK("standalone flag", 1'b0, dr)
    cmd(1, `OP_ACC_COORD, 8'h05, 8'h02, 1'b0);
    `CHK("acc to entry status", `ST_OK, st)
    cmd(1, `OP_READ_COORD, 8'h05, 8'h02, 1'b0);
    `CHK("acc to entry", 32'h12345678, va)
  endtask
  // types 0..7 each from a fresh accumulator against a fixed x of six; then invert, swap and an unknown type
  task automatic t_calc();
    word_t a, x, e;
    a = -32'sd20;
    x = 32'sh6;
    cmd(0, `OP_READ_COORD, 8'h01, 8'h00, 1'b0);
    cmd(1, `OP_XREG_CALCULATE_CMD, 8'h09, 8'h00, 1'b0);
    for (int k = 0; k < 8; k++) begin
      case (k)
        0: e = a + x;
        1: e = a - x;
        2: e = a * x;
        3: e = a / x;
        4: e = a % x;
        5: e = a & x;
        6: e = a | x;
        default: e = a ^ x;
      endcase
      cmd(0, `OP_READ_COORD, 8'h01, 8'h01, 1'b0);
      cmd(1, `OP_XREG_CALCULATE_CMD, 8'(k), 8'h00, 1'b0);
      `CHK("calc status", `ST_OK, st)
      cmd(1, `OP_ACC_PARAM, 8'(k), 8'h01, 1'b0);
      `CHK("calc result", e, pd)
      `CHK("param target", {1'b1, 8'(k), 8'h01}, {pw, pi, pa})
    end
    cmd(1, `OP_XREG_CALCULATE_CMD, 8'h08, 8'h00, 1'b0);
    cmd(1, `OP_XREG_CALCULATE_CMD, 8'h0a, 8'h00, 1'b0);
    cmd(1, `OP_ACC_PARAM, 8'h00, 8'h00, 1'b0);
    `CHK("inverted x swapped in", ~x, pd)
    cmd(1, `OP_XREG_CALCULATE_CMD, 8'h0a, 8'h00, 1'b0);
    cmd(1, `OP_ACC_PARAM, 8'h00, 8'h00, 1'b0);
    `CHK("swapped back", e, pd)
    cmd(1, `OP_XREG_CALCULATE_CMD, 8'h0b, 8'h00, 1'b0);
    `CHK("unknown type", `ST_BAD_TYPE, st)
  endtask
  task automatic t_nv();
    int w0, r0;
    w0 = host.wr_acks;
    r0 = host.rd_acks;
    persist_val_in = 1'b1;
    persist_wr_in = 1'b1;
    @(negedge clk_in);
    persist_wr_in = 1'b0;
    `CHK("persist set", 1'b1, persist_out)
    cmd(1, `OP_CAPTURE, 8'h04, 8'h00, 1'b0);
    `CHK("entry saved", w0 + 1, host.wr_acks)
    cmd(1, `OP_CAPTURE, 8'h00, 8'h00, 1'b0);
    `CHK("entry zero unsaved", w0 + 1, host.wr_acks)
    cmd(1, `OP_READ_COORD, 8'h04, `BANK_NV, 1'b0);
    `CHK("single reload reads", r0 + 6, host.rd_acks)
    cmd(1, `OP_READ_COORD, 8'h04, 8'h05, 1'b0);
    `CHK("single reload data", {8'h05, 16'h0a5c, 8'h04}, va)
    cmd(1, `OP_READ_COORD, 8'h15, `BANK_NV, 1'b0);
    `CHK("reload out of range", `ST_BAD_VAL, st)
    cmd(1, `OP_READ_COORD, 8'h00, `BANK_NV, 1'b0);
    `CHK("reload all reads", r0 + 126, host.rd_acks)
    cmd(1, `OP_READ_COORD, 8'h14, 8'h03, 1'b0);
    `CHK("reload all data", {8'h03, 16'h0a5c, 8'h14}, va)
    cmd(1, `OP_READ_COORD, 8'h00, 8'h00, 1'b0);
    `CHK("entry zero kept", 32'h6, va)
  endtask
  // start-up reload with persistence on: walks every entry but zero, sends no reply
  task automatic t_boot();
    int r0, n;
    r0 = host.rd_acks;
    boot_load_in = 1'b1;
    @(negedge clk_in);
    boot_load_in = 1'b0;
    for (n = 0; n < 1000 && nv_rd_out !== 1'b0; n++) @(negedge clk_in);
    if (n == 1000) begin
      errors++;
      complete_run();
    end
    `CHK("boot no reply", 1'b0, reply_valid_out)
    `CHK("boot reload reads", r0 + 120, host.rd_acks)
  endtask
  task automatic t_sum();
    cmd(1, `OP_READ_COORD, 8'h00, 8'h00, 1'b1);
    `CHK("bad checksum", `ST_BAD_SUM, st)
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
    `CHK("persist reset", 1'b0, persist_out)
    t_capture();
    t_acc_coord();
    t_calc();
    t_nv();
    t_boot();
    t_sum();
    complete_run();
  end
endmodule
`default_nettype wire
